// file: design/interlock_pkg.sv
// package for the run start interlock: register map, field layout, reset values, timing
// assumes a 250 MHz system clock and a plain single-cycle register port
package interlock_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLOCK_HZ        = 250_000_000;
    localparam int unsigned DELAY_UNIT_MS   = 100;
    localparam int unsigned TICK_CYCLES     = CLOCK_HZ / 1000 * DELAY_UNIT_MS;
    localparam int unsigned DELAY_MAX_S     = 60;
    localparam int unsigned DELAY_MAX_UNITS = DELAY_MAX_S * 1000 / DELAY_UNIT_MS;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_RETRY  = 8'h04;
    localparam logic [7:0] ADDR_SEARCH = 8'h08;
    localparam logic [7:0] ADDR_STATE  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h14;

    // ************************************************************
    // field positions and settings
    // ************************************************************
    localparam int unsigned CTRL_PREV_LSB  = 0;
    localparam int unsigned CTRL_SRC_LSB   = 2;
    localparam int unsigned CTRL_PORUN_BIT = 5;
    localparam int unsigned CTRL_RESUME_BIT = 6;
    localparam int unsigned CTRL_CFGOK_BIT = 7;
    localparam int unsigned RETRY_DLY_LSB  = 8;
    localparam int unsigned SS_RESUME_BIT  = 2;
    localparam int unsigned SS_POWERON_BIT = 4;

    localparam logic [1:0] PREV_NONE = 2'h0;
    localparam logic [1:0] PREV_FWD  = 2'h1;
    localparam logic [1:0] PREV_REV  = 2'h2;

    localparam logic [2:0] SRC_KEYPAD      = 3'h0;
    localparam logic [2:0] SRC_TERMINAL_A  = 3'h1;
    localparam logic [2:0] SRC_TERMINAL_B  = 3'h2;

    localparam logic [3:0] ATTEMPT_MAX     = 4'hA;
    localparam logic [3:0] ATTEMPT_RESET   = 4'h0;
    localparam logic [9:0] DELAY_RESET     = 10'h00A;

    // interrupt status bits
    localparam int unsigned IRQ_BLOCKED  = 0;
    localparam int unsigned IRQ_FAULT    = 1;
    localparam int unsigned IRQ_RESUME   = 2;
    localparam int unsigned IRQ_EXHAUST  = 3;
    localparam int unsigned IRQ_W        = 4;

    typedef struct packed {
        logic       cfg_done;
        logic       resume_en;
        logic       power_on_run;
        logic [2:0] cmd_source;
        logic [1:0] run_prevent;
    } ctrl_t;

    typedef struct packed {
        logic [9:0] delay;
        logic [3:0] count;
    } retry_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DECEL,
        ST_TRIPPED,
        ST_WAIT
    } run_state_t;

endpackage

// file: design/tick_divider.sv
// one-cycle enable pulse every PERIOD clocks
// assumes a single clock domain
`timescale 1ns/10ps
module tick_divider #(
    parameter int unsigned PERIOD = 25_000_000
) (
    input  wire logic clock,
    input  wire logic arst_n,
    output logic      tick
);
    localparam int unsigned CW = $clog2(PERIOD + 1);

    logic [CW-1:0] count_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (count_q == CW'(PERIOD - 1)) begin
            count_q <= '0;
            tick    <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
            tick    <= 1'b0;
        end
    end
endmodule

// file: design/run_rearm.sv
// decides whether a held run input may start the drive
// assumes run_level is synchronous; open_window pulses once when settings become valid
`timescale 1ns/10ps
module run_rearm (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic run_level,
    input  wire logic open_window,
    input  wire logic allow_held,
    input  wire logic disarm,
    output logic      armed
);
    // a run input already closed at power up only counts when allowed; otherwise
    // it must open once before it can start anything
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
        end else if (open_window) begin
            // whatever the input did before settings loaded does not count
            armed <= !run_level || allow_held;
        end else if (!run_level) begin
            armed <= 1'b1;
        end else if (disarm) begin
            armed <= 1'b0;
        end
    end

    a_held_needs_allow: assert property (@(posedge clock) disable iff (!arst_n)
        (open_window && run_level && !allow_held) |=> !armed)
        else $error("held run input armed without permission");
endmodule

// file: design/run_start_interlock.sv
// run command qualification: direction blocking, power-on run (terminal source, needs auto resume on too), fault auto resume
// assumes synchronous inputs, one 250 MHz clock, single-cycle register port
`timescale 1ns/10ps
module run_start_interlock
    import interlock_pkg::*;
#(
    parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        run_fwd,
    input  wire logic        run_rev,
    input  wire logic        key_fwd,
    input  wire logic        key_rev,
    input  wire logic        key_stop,
    input  wire logic        fault,
    input  wire logic        fault_reset,
    input  wire logic        at_zero_speed,
    output logic             drive_enable,
    output logic             ramp_accel,
    output logic             ramp_decel,
    output logic             dir_reverse,
    output logic             search_start,
    output logic             irq
);
    // ************************************************************
    // registers
    // ************************************************************
    ctrl_t      ctrl_q;
    retry_t     retry_q;
    logic [7:0] search_q;
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_mk_q;
    logic [IRQ_W-1:0] irq_set;
    logic       cfg_seen_q;
    run_state_t state_q;
    logic [3:0] attempts_q;
    logic [9:0] wait_q;
    logic       rev_q;
    logic       drive_q;
    logic       search_q_pulse;

    logic wr_retry;
    assign wr_retry = reg_write && (reg_addr == ADDR_RETRY);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q   <= '0;
            retry_q  <= '{delay: DELAY_RESET, count: ATTEMPT_RESET};
            search_q <= 8'h00;
            irq_mk_q <= '0;
        end else if (reg_write) begin
            case (reg_addr)
                ADDR_CTRL: begin
                    // settings 3 is not a prevention choice, stored as written and blocks neither direction
                    ctrl_q <= ctrl_t'(reg_wdata[7:0]);
                end
                ADDR_RETRY: begin
                    retry_q.count <= (reg_wdata[3:0] > ATTEMPT_MAX) ? ATTEMPT_MAX
                                     : reg_wdata[3:0];
                    retry_q.delay <= (reg_wdata[RETRY_DLY_LSB +: 10] > 10'(DELAY_MAX_UNITS))
                                     ? 10'(DELAY_MAX_UNITS)
                                     : reg_wdata[RETRY_DLY_LSB +: 10];
                end
                ADDR_SEARCH: search_q <= reg_wdata[7:0];
                ADDR_IRQ_MK: irq_mk_q <= reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky status: a new event in the clearing cycle survives
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_st_q <= '0;
        end else if (reg_write && reg_addr == ADDR_IRQ_ST) begin
            irq_st_q <= (irq_st_q & ~reg_wdata[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_st_q <= irq_st_q | irq_set;
        end
    end
    assign irq = |(irq_st_q & irq_mk_q);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_CTRL:   reg_rdata <= {24'h000000, ctrl_q};
                ADDR_RETRY:  reg_rdata <= {14'h0000, retry_q.delay, 4'h0, retry_q.count};
                ADDR_SEARCH: reg_rdata <= {24'h000000, search_q};
                ADDR_STATE:  reg_rdata <= {20'h00000, attempts_q, 1'b0, rev_q,
                                           drive_enable, 2'b00, state_q};
                ADDR_IRQ_ST: reg_rdata <= {28'h0000000, irq_st_q};
                ADDR_IRQ_MK: reg_rdata <= {28'h0000000, irq_mk_q};
                default:     reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // command decode
    // ************************************************************
    logic terminal_src;
    logic run_level;
    logic want_rev;
    logic key_start;
    logic dir_blocked;
    logic stop_req;
    logic open_window;
    logic armed;
    logic tick;

    assign terminal_src = (ctrl_q.cmd_source == SRC_TERMINAL_A)
                       || (ctrl_q.cmd_source == SRC_TERMINAL_B);
    assign run_level    = terminal_src && (run_fwd || run_rev);
    assign key_start    = (ctrl_q.cmd_source == SRC_KEYPAD) && (key_fwd || key_rev);
    assign want_rev     = terminal_src ? (run_rev && !run_fwd) : (key_rev && !key_fwd);
    assign dir_blocked  = (want_rev && ctrl_q.run_prevent == PREV_REV)
                       || (!want_rev && ctrl_q.run_prevent == PREV_FWD);
    assign stop_req     = terminal_src ? !run_level
                                       : (ctrl_q.cmd_source == SRC_KEYPAD && key_stop);

    // settings are only trustworthy once software marks them loaded; that moment
    // stands in for power up
    assign open_window  = ctrl_q.cfg_done && !cfg_seen_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_seen_q <= 1'b0;
        end else if (ctrl_q.cfg_done) begin
            cfg_seen_q <= 1'b1;
        end
    end

    run_rearm u_rearm (
        .clock       (clock),
        .arst_n      (arst_n),
        .run_level   (run_level),
        .open_window (open_window),
        .allow_held  (terminal_src && ctrl_q.power_on_run && ctrl_q.resume_en),
        // a trip forgets a held input, so only the resume path may restart
        .disarm      (state_q == ST_TRIPPED),
        .armed       (armed)
    );

    tick_divider #(
        .PERIOD (TICK_PERIOD)
    ) u_tick (
        .clock  (clock),
        .arst_n (arst_n),
        .tick   (tick)
    );

    // ************************************************************
    // run sequencer
    // ************************************************************
    logic term_start;
    logic resume_ok;
    assign term_start = cfg_seen_q && armed && run_level && !open_window;
    assign resume_ok  = ctrl_q.resume_en && (attempts_q != 4'h0) && run_level;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q        <= ST_IDLE;
            attempts_q     <= ATTEMPT_RESET;
            wait_q         <= '0;
            rev_q          <= 1'b0;
            drive_q        <= 1'b0;
            search_q_pulse <= 1'b0;
            irq_set        <= '0;
        end else begin
            search_q_pulse <= 1'b0;
            irq_set        <= '0;
            if (wr_retry) begin
                attempts_q <= (reg_wdata[3:0] > ATTEMPT_MAX) ? ATTEMPT_MAX : reg_wdata[3:0];
            end
            if (fault && state_q != ST_TRIPPED) begin
                state_q            <= ST_TRIPPED;
                drive_q            <= 1'b0;
                irq_set[IRQ_FAULT] <= 1'b1;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if ((term_start || key_start) && dir_blocked) begin
                            irq_set[IRQ_BLOCKED] <= 1'b1;
                        end else if (term_start || key_start) begin
                            state_q    <= ST_RUN;
                            drive_q    <= 1'b1;
                            rev_q      <= want_rev;
                            attempts_q <= retry_q.count;
                            search_q_pulse <= search_q[SS_POWERON_BIT];
                        end
                    end
                    ST_RUN: begin
                        if (stop_req || (terminal_src && dir_blocked)) begin
                            state_q <= ST_DECEL;
                            irq_set[IRQ_BLOCKED] <= !stop_req;
                        end else if (key_start && dir_blocked) begin
                            state_q <= ST_DECEL;
                            irq_set[IRQ_BLOCKED] <= 1'b1;
                        end
                    end
                    ST_DECEL: begin
                        // drive stays on so the ramp can bring the output to zero
                        if (at_zero_speed) begin
                            state_q <= ST_IDLE;
                            drive_q <= 1'b0;
                        end
                    end
                    ST_TRIPPED: begin
                        if (fault_reset && !fault) begin
                            if (resume_ok) begin
                                state_q <= ST_WAIT;
                                wait_q  <= retry_q.delay;
                            end else begin
                                state_q <= ST_IDLE;
                                irq_set[IRQ_EXHAUST] <= ctrl_q.resume_en;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (!run_level) begin
                            state_q <= ST_IDLE;
                        end else if (wait_q == 10'h000) begin
                            state_q    <= ST_RUN;
                            drive_q    <= 1'b1;
                            rev_q      <= want_rev;
                            attempts_q <= attempts_q - 4'h1;
                            irq_set[IRQ_RESUME] <= 1'b1;
                            search_q_pulse <= search_q[SS_RESUME_BIT];
                        end else if (tick) begin
                            wait_q <= wait_q - 10'h001;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        drive_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // fault gates the drive combinationally so no cycle of output follows it
    assign drive_enable = drive_q && !fault;
    assign ramp_accel   = (state_q == ST_RUN) && !fault;
    assign ramp_decel   = (state_q == ST_DECEL) && !fault;
    assign dir_reverse  = rev_q;
    assign search_start = search_q_pulse;

    // ************************************************************
    // checks
    // ************************************************************
    a_fault_cuts_drive: assert property (@(posedge clock) disable iff (!arst_n)
        fault |-> !drive_enable ##1 (state_q == ST_TRIPPED))
        else $error("drive not removed on fault");

    a_blocked_rev_decel: assert property (@(posedge clock) disable iff (!arst_n)
        (state_q == ST_RUN && !fault && terminal_src && run_level && want_rev
         && ctrl_q.run_prevent == PREV_REV) |=> (state_q == ST_DECEL && drive_q))
        else $error("blocked reverse did not ramp down");

    a_blocked_fwd_decel: assert property (@(posedge clock) disable iff (!arst_n)
        (state_q == ST_RUN && !fault && terminal_src && run_level && !want_rev
         && ctrl_q.run_prevent == PREV_FWD) |=> (state_q == ST_DECEL))
        else $error("blocked forward did not ramp down");

    a_prev_none_free: assert property (@(posedge clock) disable iff (!arst_n)
        (ctrl_q.run_prevent == PREV_NONE) |-> !dir_blocked)
        else $error("direction blocked with prevention off");

    a_poweron_source: assert property (@(posedge clock) disable iff (!arst_n)
        (open_window && run_level && !ctrl_q.power_on_run) |=> !armed)
        else $error("power-on run taken while disabled");

    a_no_resume_off: assert property (@(posedge clock) disable iff (!arst_n)
        (state_q == ST_TRIPPED && !ctrl_q.resume_en) |=> state_q != ST_WAIT)
        else $error("resume with auto resume off");

    a_zero_attempts: assert property (@(posedge clock) disable iff (!arst_n)
        (state_q == ST_TRIPPED && attempts_q == 4'h0) |=> state_q != ST_WAIT)
        else $error("resume with no attempts left");

    a_resume_start: assert property (@(posedge clock) disable iff (!arst_n)
        (state_q == ST_TRIPPED && fault_reset && !fault && resume_ok)
        |=> (state_q == ST_WAIT && wait_q == retry_q.delay))
        else $error("resume did not begin its delay");

    a_attempt_limit: assert property (@(posedge clock) disable iff (!arst_n)
        attempts_q <= ATTEMPT_MAX)
        else $error("attempt count above limit");

    a_resume_search: assert property (@(posedge clock) disable iff (!arst_n)
        (state_q == ST_WAIT && !fault && run_level && wait_q == 10'h000)
        |=> (search_start == search_q[SS_RESUME_BIT] && state_q == ST_RUN))
        else $error("resume speed search mismatch");

    a_start_search: assert property (@(posedge clock) disable iff (!arst_n)
        (state_q == ST_IDLE && !fault && term_start && !dir_blocked)
        |=> (search_start == search_q[SS_POWERON_BIT] && ramp_accel))
        else $error("start speed search mismatch");
endmodule

// file: tb/run_source.sv
// model of the terminal run contacts and keypad keys feeding the interlock
// assumes a rising-edge clock shared with the block under test
`timescale 1ns/10ps
module run_source (
    input  wire logic clock,
    output logic      run_fwd,
    output logic      run_rev,
    output logic      key_fwd,
    output logic      key_rev,
    output logic      key_stop
);
    // keys start released; press drives them, so both terminal and keypad sources are exercised
    initial begin
        run_fwd  = 1'b0;
        run_rev  = 1'b0;
        key_fwd  = 1'b0;
        key_rev  = 1'b0;
        key_stop = 1'b0;
    end

    // contacts are levels held until told otherwise; open reads low
    task automatic set_run(input logic f, input logic r);
        @(posedge clock);
        run_fwd <= f;
        run_rev <= r;
    endtask

    // keys are one-cycle presses
    task automatic press(input logic f, input logic r, input logic s);
        @(posedge clock);
        key_fwd  <= f;
        key_rev  <= r;
        key_stop <= s;
        @(posedge clock);
        key_fwd  <= 1'b0;
        key_rev  <= 1'b0;
        key_stop <= 1'b0;
    endtask
endmodule

// file: tb/tb_run_start_interlock.sv
// self-checking bench for the run start interlock
// assumes tick period 4 so resume delays are a few cycles per unit
`timescale 1ns/10ps
module tb_run_start_interlock;
    import interlock_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] srch;
        logic       f, r, drv, dir, ss, blk;
    } row_t;
    logic        clock, arst_n, reg_write, reg_read, fault, fault_reset, at_zero_speed;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic        run_fwd, run_rev, key_fwd, key_rev, key_stop;
    logic        drive_enable, ramp_accel, ramp_decel, dir_reverse, search_start, irq;
    logic        seen;
    int          n_mismatch, num_checks, cycles;
    // ************************************************************
    // held contacts then settings load: held input at power up
    // ************************************************************
    row_t rows [11] = '{
        '{8'hE4, 8'h00, 1, 0, 1, 0, 0, 0},
        '{8'hE4, 8'h00, 0, 1, 1, 1, 0, 0},
        '{8'hE5, 8'h00, 1, 0, 0, 0, 0, 1},
        '{8'hE5, 8'h00, 0, 1, 1, 1, 0, 0},
        '{8'hE6, 8'h00, 0, 1, 0, 0, 0, 1},
        '{8'hE6, 8'h00, 1, 0, 1, 0, 0, 0},
        '{8'hE8, 8'h10, 1, 0, 1, 0, 1, 0},
        '{8'hE4, 8'h04, 1, 0, 1, 0, 0, 0},
        '{8'hC4, 8'h00, 1, 0, 0, 0, 0, 0},
        '{8'hA4, 8'h00, 1, 0, 0, 0, 0, 0},
        '{8'hE0, 8'h00, 1, 0, 0, 0, 0, 0}
    };
    run_start_interlock #(.TICK_PERIOD(4)) u_dut (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .run_fwd(run_fwd), .run_rev(run_rev), .key_fwd(key_fwd), .key_rev(key_rev),
        .key_stop(key_stop), .fault(fault), .fault_reset(fault_reset),
        .at_zero_speed(at_zero_speed), .drive_enable(drive_enable), .ramp_accel(ramp_accel),
        .ramp_decel(ramp_decel), .dir_reverse(dir_reverse), .search_start(search_start),
        .irq(irq));
    run_source u_src (
        .clock(clock), .run_fwd(run_fwd), .run_rev(run_rev),
        .key_fwd(key_fwd), .key_rev(key_rev), .key_stop(key_stop));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // search pulse lasts one cycle, so latch it for later checks
    always @(posedge clock) begin
        if (search_start === 1'b1) seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic do_reset();
        @(posedge clock);
        arst_n <= 1'b0; fault <= 1'b0; fault_reset <= 1'b0; at_zero_speed <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
    endtask
    task automatic fault_cycle(input logic exp_run);
        int k;
        seen = 1'b0;
        @(posedge clock);
        fault <= 1'b1;
        #1 check({drive_enable, ramp_accel}, 0);
        @(posedge clock);
        fault <= 1'b0; fault_reset <= 1'b1;
        @(posedge clock);
        fault_reset <= 1'b0;
        repeat (6) @(posedge clock);
        #1 check(drive_enable, 0);
        for (k = 0; k < 30 && drive_enable !== 1'b1; k++) @(posedge clock);
        #1 check(drive_enable, exp_run);
        if (exp_run) check(seen, 1);
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {arst_n, reg_write, reg_read, fault, fault_reset, at_zero_speed} = '0;
        reg_addr = 8'h00; reg_wdata = 32'h0; seen = 1'b0;
        n_mismatch = 0; num_checks = 0; cycles = 0;
        foreach (rows[i]) begin
            do_reset();
            u_src.set_run(rows[i].f, rows[i].r);
            wr(ADDR_SEARCH, {24'h0, rows[i].srch});
            seen = 1'b0;
            wr(ADDR_CTRL, {24'h0, rows[i].ctrl});
            repeat (6) @(posedge clock);
            #1 check(drive_enable, rows[i].drv);
            if (rows[i].drv) check(dir_reverse, rows[i].dir);
            check(seen, rows[i].ss);
            rd(ADDR_IRQ_ST, d);
            check(d[0], rows[i].blk);
            $display("row %0d done", i);
        end
        do_reset();
        rd(ADDR_CTRL, d);
        check(d, 0);
        rd(ADDR_RETRY, d);
        check(d, {14'h0, DELAY_RESET, 4'h0, ATTEMPT_RESET});
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, d);
        check(d, 0);
        $display("reset test done");
        wr(ADDR_CTRL, 32'h0000_00C4);
        repeat (4) @(posedge clock);
        #1 check(drive_enable, 0);
        u_src.set_run(1'b0, 1'b0);
        u_src.set_run(1'b1, 1'b0);
        repeat (4) @(posedge clock);
        #1 check(drive_enable, 1);
        // running forward, then reverse requested while reverse is blocked
        u_src.set_run(1'b1, 1'b0);
        wr(ADDR_CTRL, 32'h0000_00E6);
        repeat (6) @(posedge clock);
        u_src.set_run(1'b0, 1'b1);
        repeat (4) @(posedge clock);
        #1 check(ramp_decel, 1);
        rd(ADDR_IRQ_ST, d);
        check(d[1:0], 2'b01);
        @(posedge clock);
        at_zero_speed <= 1'b1;
        repeat (3) @(posedge clock);
        rd(ADDR_STATE, d);
        check(d[2:0], 0);
        $display("blocked while running done");
        // keypad source with reverse blocked
        do_reset();
        u_src.set_run(1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0082);
        u_src.press(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clock);
        #1 check(drive_enable, 0);
        u_src.press(1'b1, 1'b0, 1'b0);
        repeat (2) @(posedge clock);
        #1 check({drive_enable, dir_reverse}, 2'b10);
        u_src.press(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clock);
        #1 check({ramp_decel, drive_enable}, 2'b11);
        rd(ADDR_IRQ_ST, d);
        check(d[1:0], 2'b01);
        @(posedge clock);
        at_zero_speed <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check(drive_enable, 0);
        @(posedge clock);
        at_zero_speed <= 1'b0;
        u_src.press(1'b1, 1'b0, 1'b0);
        u_src.press(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge clock);
        #1 check(ramp_decel, 1);
        $display("keypad test done");
        do_reset();
        u_src.set_run(1'b1, 1'b0);
        wr(ADDR_RETRY, 32'h0000_0302);
        wr(ADDR_SEARCH, 32'h0000_0004);
        wr(ADDR_IRQ_MK, 32'h0000_0004);
        wr(ADDR_CTRL, 32'h0000_00E4);
        repeat (6) @(posedge clock);
        fault_cycle(1'b1);
        rd(ADDR_STATE, d);
        check(d[11:8], 1);
        check(irq, 1);
        wr(ADDR_IRQ_ST, 32'h0000_0004);
        repeat (2) @(posedge clock);
        #1 check(irq, 0);
        wr(ADDR_RETRY, 32'h0000_0300);
        fault_cycle(1'b0);
        rd(ADDR_IRQ_ST, d);
        check(d[3], 1);
        wr(ADDR_RETRY, 32'h0000_000F);
        rd(ADDR_RETRY, d);
        check(d, 32'h0000_000A);
        $display("fault resume test done");
        close_out();
    end
endmodule
